// ===== design/odpoc_pkg.sv
package odpoc_pkg;

    // Pin and field widths
    localparam int RANGE_W = 4;
    localparam int PIN_W   = 8;

    // Bit positions inside the synchronised pin bundle
    localparam int PIN_MODE_SELECT = 0;
    localparam int PIN_CLEAR       = 1;
    localparam int PIN_OUT_ENABLE  = 2;
    localparam int PIN_CLEAR_LEVEL = 3;
    localparam int PIN_RANGE_LSB   = 4;

    // Range code bit that steers the active channel (1 = current, 0 = voltage)
    localparam int RANGE_CURRENT_BIT = 3;

    // Reset values of the control register fields
    localparam logic [RANGE_W-1:0] RANGE_RST     = 4'h0;
    localparam logic               OUT_EN_RST    = 1'h0;
    localparam logic               CLR_LEVEL_RST = 1'h0;
    localparam logic [PIN_W-1:0]   PIN_RST       = 8'h00;

    // Level on the mode-select pin that selects hardware mode
    localparam logic MODE_HW_LEVEL = 1'h1;

    // Settling time before the power-up sample, in ns, and its cycle count at 20 MHz
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SETTLE_TIME_NS = 200;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W   = 4;
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYCLES - 1);

    // Sequencer states
    typedef enum logic [1:0]
    {
        ODPOC_ST_SETTLE,
        ODPOC_ST_SAMPLE,
        ODPOC_ST_SOFT,
        ODPOC_ST_HARD
    } odpoc_state_type;

endpackage

// ===== design/odpoc_sync.sv
`timescale 1ns/10ps
module odpoc_sync
    import odpoc_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    input  wire logic [odpoc_pkg::PIN_W-1:0] i_async,
    output logic      [odpoc_pkg::PIN_W-1:0] o_sync
);

    genvar gi;

    // Three stages per pin; a change is taken once stages two and three agree
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1)
        begin : g_bit
            logic meta_r;
            logic stage2_r;
            logic stage3_r;
            logic out_r;

            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    meta_r   <= 1'h0;
                    stage2_r <= 1'h0;
                    stage3_r <= 1'h0;
                end
                else
                begin
                    meta_r   <= i_async[gi];
                    stage2_r <= meta_r;
                    stage3_r <= stage2_r;
                end
            end

            // Filtered level follows only when the two late stages match
            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    out_r <= 1'h0;
                else if (stage2_r == stage3_r)
                    out_r <= stage3_r;
            end

            assign o_sync[gi] = out_r;
        end
    endgenerate

endmodule

// ===== design/odpoc_mode_latch.sv
`timescale 1ns/10ps
module odpoc_mode_latch
    import odpoc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_sample,
    input  wire logic i_mode_level,
    input  wire logic i_clear_level,
    output logic      o_hw_mode,
    output logic      o_clear_at_power_up
);

    logic hw_mode_r;
    logic clear_pu_r;

    // Caught once at the power-up sample, then held until the next power cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hw_mode_r  <= 1'h0;
            clear_pu_r <= 1'h0;
        end
        else if (i_sample)
        begin
            hw_mode_r  <= (i_mode_level == MODE_HW_LEVEL);
            clear_pu_r <= i_clear_level;
        end
    end

    assign o_hw_mode           = hw_mode_r;
    assign o_clear_at_power_up = clear_pu_r;

endmodule

// ===== design/odpoc_top.sv
`timescale 1ns/10ps
module odpoc_top
    import odpoc_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_reset_n,
    input  wire logic                          i_mode_select_pin,
    input  wire logic                          i_clear_pin,
    input  wire logic                          i_output_enable_pin,
    input  wire logic                          i_clear_level_select_pin,
    input  wire logic [odpoc_pkg::RANGE_W-1:0] i_range_select_pins,
    input  wire logic                          i_ctrl_write,
    input  wire logic [odpoc_pkg::RANGE_W-1:0] i_ctrl_range_select,
    input  wire logic                          i_ctrl_output_enable_bit,
    input  wire logic                          i_ctrl_clear_level_select,
    output logic                               o_voltage_output_pin_en,
    output logic                               o_current_output_pin_en,
    output logic                               o_force_zero_volt,
    output logic                               o_clear_active,
    output logic                               o_clear_level,
    output logic      [odpoc_pkg::RANGE_W-1:0] o_range,
    output logic                               o_output_enable_bit,
    output logic                               o_hw_mode,
    output logic                               o_ready
);

    logic                    rst_meta_r;
    logic                    rst_n_r;
    logic [PIN_W-1:0]        pins_async;
    logic [PIN_W-1:0]        pins;
    odpoc_state_type         state_r;
    odpoc_state_type         state_nxt;
    logic [SETTLE_CNT_W-1:0] settle_cnt_r;
    logic                    sample;
    logic                    hw_mode;
    logic                    clear_pu;
    logic [RANGE_W-1:0]      range_r;
    logic                    out_en_r;
    logic                    clr_level_r;
    logic                    enabled_once_r;
    logic                    clear_state_r;
    logic                    clear_now;
    logic                    run_sw;
    logic                    run_hw;
    logic [RANGE_W-1:0]      act_range;
    logic                    act_en;
    logic                    act_clr_level;
    logic                    want_current;
    logic                    v_en_nxt;
    logic                    i_en_nxt;
    logic                    zero_nxt;
    logic                    clr_act_nxt;

    // Reset release through two flip-flops
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta_r <= 1'h0;
            rst_n_r    <= 1'h0;
        end
        else
        begin
            rst_meta_r <= 1'h1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Bundle the asynchronous pins for the synchroniser
    assign pins_async[PIN_MODE_SELECT]                      = i_mode_select_pin;
    assign pins_async[PIN_CLEAR]                            = i_clear_pin;
    assign pins_async[PIN_OUT_ENABLE]                       = i_output_enable_pin;
    assign pins_async[PIN_CLEAR_LEVEL]                      = i_clear_level_select_pin;
    assign pins_async[PIN_RANGE_LSB +: RANGE_W]             = i_range_select_pins;

    odpoc_sync u_sync
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_r),
        .i_async (pins_async),
        .o_sync  (pins)
    );

    odpoc_mode_latch u_mode
    (
        .i_clk               (i_clk),
        .i_rst_n             (rst_n_r),
        .i_sample            (sample),
        .i_mode_level        (pins[PIN_MODE_SELECT]),
        .i_clear_level       (pins[PIN_CLEAR]),
        .o_hw_mode           (hw_mode),
        .o_clear_at_power_up (clear_pu)
    );

    // Wait for the pin synchroniser to settle before the power-up sample
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            settle_cnt_r <= '0;
        else if (state_r == ODPOC_ST_SETTLE)
            settle_cnt_r <= settle_cnt_r + 1'h1;
    end

    // Power-up sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ODPOC_ST_SETTLE:
            begin
                if (settle_cnt_r == SETTLE_LAST)
                    state_nxt = ODPOC_ST_SAMPLE;
            end
            ODPOC_ST_SAMPLE:
            begin
                state_nxt = (pins[PIN_MODE_SELECT] == MODE_HW_LEVEL) ? ODPOC_ST_HARD
                                                                     : ODPOC_ST_SOFT;
            end
            ODPOC_ST_SOFT:
                state_nxt = ODPOC_ST_SOFT;
            ODPOC_ST_HARD:
                state_nxt = ODPOC_ST_HARD;
            default:
                state_nxt = ODPOC_ST_SETTLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            state_r <= ODPOC_ST_SETTLE;
        else
            state_r <= state_nxt;
    end

    // Phase decodes: sample strobe and the running mode
    assign sample = (state_r == ODPOC_ST_SAMPLE);
    assign run_sw = (state_r == ODPOC_ST_SOFT) && !hw_mode;
    assign run_hw = (state_r == ODPOC_ST_HARD) && hw_mode;

    // Control register: zero at power-on, written only in software mode
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            range_r     <= RANGE_RST;
            out_en_r    <= OUT_EN_RST;
            clr_level_r <= CLR_LEVEL_RST;
        end
        else if (run_sw && i_ctrl_write)
        begin
            range_r     <= i_ctrl_range_select;
            out_en_r    <= i_ctrl_output_enable_bit;
            clr_level_r <= i_ctrl_clear_level_select;
        end
    end

    // Remembers that software has enabled the output at least once
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            enabled_once_r <= 1'h0;
        else if (run_sw && i_ctrl_write && i_ctrl_output_enable_bit)
            enabled_once_r <= 1'h1;
    end

    // Clear state: entered by the enabling write, or in hardware mode, with clear high; left on clear low
    assign clear_now = pins[PIN_CLEAR];

    // Clear state register; a low clear pin always wins
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            clear_state_r <= 1'h0;
        else if (!clear_now)
            clear_state_r <= 1'h0;
        else if (run_sw && i_ctrl_write && i_ctrl_output_enable_bit)
            clear_state_r <= 1'h1;
        else if (run_hw)
            clear_state_r <= 1'h1;
    end

    // Pick the active settings from pins in hardware mode, register in software
    assign act_range     = run_hw ? pins[PIN_RANGE_LSB +: RANGE_W] : range_r;
    assign act_en        = run_hw ? pins[PIN_OUT_ENABLE] : out_en_r;
    assign act_clr_level = run_hw ? pins[PIN_CLEAR_LEVEL] : clr_level_r;
    assign want_current  = act_range[RANGE_CURRENT_BIT];

    // Channel drive decisions
    always_comb
    begin
        v_en_nxt    = 1'h0;
        i_en_nxt    = 1'h0;
        zero_nxt    = 1'h0;
        clr_act_nxt = 1'h0;
        if (run_sw && !enabled_once_r)
        begin
            // Power-up condition before the first enabling write
            v_en_nxt = clear_pu;
            zero_nxt = clear_pu;
            i_en_nxt = 1'h0;
        end
        else if ((run_sw || run_hw) && act_en)
        begin
            v_en_nxt    = !want_current;
            i_en_nxt    = want_current;
            clr_act_nxt = clear_state_r;
        end
        else
        begin
            v_en_nxt = 1'h0;
            i_en_nxt = 1'h0;
        end
    end

    // Channel drive enables; voltage wins any tie so one channel at most
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_voltage_output_pin_en <= 1'h0;
            o_current_output_pin_en <= 1'h0;
        end
        else
        begin
            o_voltage_output_pin_en <= v_en_nxt;
            o_current_output_pin_en <= i_en_nxt && !v_en_nxt;
        end
    end

    // Zero-volt drive held through the power-up condition if clear was high at the power-up sample
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            o_force_zero_volt <= 1'h0;
        else
            o_force_zero_volt <= zero_nxt;
    end

    // Clear state and the clear level that goes with it
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_clear_active <= 1'h0;
            o_clear_level  <= 1'h0;
        end
        else
        begin
            o_clear_active <= clr_act_nxt;
            o_clear_level  <= act_clr_level;
        end
    end

    // Active range and the readback of the software enable bit
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_range             <= RANGE_RST;
            o_output_enable_bit <= OUT_EN_RST;
        end
        else
        begin
            o_range             <= act_range;
            o_output_enable_bit <= out_en_r;
        end
    end

    // Sampled mode and the ready flag
    always_ff @(posedge i_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_hw_mode <= 1'h0;
            o_ready   <= 1'h0;
        end
        else
        begin
            o_hw_mode <= hw_mode;
            o_ready   <= run_sw || run_hw;
        end
    end

endmodule

// ===== bench/odpoc_top_asserts.sv
`timescale 1ns/10ps
module odpoc_top_asserts
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_mode_select_pin,
    input wire logic i_clear_pin,
    input wire logic i_output_enable_pin,
    input wire logic i_ctrl_write,
    input wire logic i_ctrl_output_enable_bit,
    input wire logic o_voltage_output_pin_en,
    input wire logic o_current_output_pin_en,
    input wire logic o_force_zero_volt,
    input wire logic o_clear_active,
    input wire logic o_output_enable_bit,
    input wire logic o_hw_mode,
    input wire logic o_ready
);
    logic sw_wr;

    // A control write taken while software mode runs
    assign sw_wr = i_ctrl_write && o_ready && !o_hw_mode;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    // Channel and write-port checks
    AST_ONE_CHANNEL: assert property (
        !(o_voltage_output_pin_en && o_current_output_pin_en))
        else $error("both channels driven");
    AST_EN_BIT: assert property (
        sw_wr |-> ##2 o_output_enable_bit == $past(i_ctrl_output_enable_bit, 2))
        else $error("enable bit readback wrong");
    AST_DISABLE: assert property (
        sw_wr && !i_ctrl_output_enable_bit |->
            ##2 !o_voltage_output_pin_en && !o_current_output_pin_en)
        else $error("disabled output still driven");
    AST_CURRENT_IDLE: assert property (
        o_ready && !o_hw_mode && !o_output_enable_bit |-> !o_current_output_pin_en)
        else $error("current channel driven while disabled");
    // Power-up sampling checks
    AST_MODE_SAMPLE: assert property (
        $rose(o_ready) |-> o_hw_mode == i_mode_select_pin)
        else $error("mode not taken from pin");
    AST_POWERUP_CLEAR: assert property (
        $rose(o_ready) && !o_hw_mode |-> ##[0:2]
            (o_force_zero_volt == i_clear_pin && o_voltage_output_pin_en == i_clear_pin))
        else $error("power-up voltage state wrong");
    AST_MODE_HELD: assert property (
        $past(o_ready) |-> o_ready && $stable(o_hw_mode))
        else $error("sampled mode changed");
    AST_RESET_ZERO: assert property (
        disable iff (1'b0)
        !i_reset_n |-> !o_ready && !o_output_enable_bit &&
            !o_clear_active && !o_force_zero_volt)
        else $error("state not cleared in reset");
    // Clear and hardware enable checks; pins held long enough to pass the filter for clear entry and hardware off
    AST_CLEAR_ENTRY: assert property (
        (i_clear_pin) [*6] ##1 (sw_wr && i_ctrl_output_enable_bit && i_clear_pin)
            |-> ##2 o_clear_active)
        else $error("clear state not entered");
    AST_CLEAR_EXIT: assert property (
        $fell(i_clear_pin) |-> ##[1:8] !o_clear_active)
        else $error("clear state not left");
    AST_HW_OFF: assert property (
        (!i_output_enable_pin) [*6] ##1 (o_ready && o_hw_mode && !i_output_enable_pin)
            |-> !o_voltage_output_pin_en && !o_current_output_pin_en)
        else $error("hardware disable ignored");

    // Main scenarios reached
    CV_HW_READY: cover property ($rose(o_ready) && o_hw_mode);
    CV_SW_ENABLE: cover property (sw_wr && i_ctrl_output_enable_bit);
    CV_CLEAR_EXIT: cover property ($fell(o_clear_active));
endmodule

bind odpoc_top odpoc_top_asserts u_chk (.i_clk, .i_reset_n, .i_mode_select_pin, .i_clear_pin,
    .i_output_enable_pin, .i_ctrl_write, .i_ctrl_output_enable_bit, .o_voltage_output_pin_en,
    .o_current_output_pin_en, .o_force_zero_volt, .o_clear_active, .o_output_enable_bit,
    .o_hw_mode, .o_ready);

// ===== bench/odpoc_host_model.sv
`timescale 1ns/10ps
module odpoc_host_model
    import odpoc_pkg::*;
(
    input  wire logic                          i_clk,
    output logic                               o_reset_n,
    output logic                               o_mode_select_pin,
    output logic                               o_clear_pin,
    output logic                               o_output_enable_pin,
    output logic                               o_clear_level_select_pin,
    output logic      [odpoc_pkg::RANGE_W-1:0] o_range_select_pins,
    output logic                               o_ctrl_write,
    output logic      [odpoc_pkg::RANGE_W-1:0] o_ctrl_range_select,
    output logic                               o_ctrl_output_enable_bit,
    output logic                               o_ctrl_clear_level_select
);
    // Idle levels; power goes down just after time zero
    initial
    begin
        o_reset_n = 1'b1;
        {o_mode_select_pin, o_clear_pin, o_output_enable_pin, o_clear_level_select_pin} = 4'h0;
        {o_range_select_pins, o_ctrl_write, o_ctrl_range_select} = 9'h000;
        {o_ctrl_output_enable_bit, o_ctrl_clear_level_select} = 2'h0;
        #1 o_reset_n = 1'b0;
    end

    // Power cycle; pins stay put through the power-up sample
    task automatic power_up(input logic mode, input logic clr, input logic [RANGE_W-1:0] rng);
        @(negedge i_clk);
        o_reset_n = 1'b0;
        o_mode_select_pin = mode;
        o_clear_pin = clr;
        o_output_enable_pin = 1'b0;
        o_clear_level_select_pin = 1'b1;
        o_range_select_pins = rng;
        repeat (5) @(negedge i_clk);
        o_reset_n = 1'b1;
    endtask

    // One control write; fields are scrambled once the write is taken
    task automatic ctrl_write(input logic [RANGE_W-1:0] rng, input logic en, input logic cl);
        @(negedge i_clk);
        o_ctrl_write = 1'b1;
        o_ctrl_range_select = rng;
        o_ctrl_output_enable_bit = en;
        o_ctrl_clear_level_select = cl;
        @(negedge i_clk);
        o_ctrl_write = 1'b0;
        o_ctrl_range_select = ~rng;
        o_ctrl_output_enable_bit = ~en;
        o_ctrl_clear_level_select = ~cl;
    endtask

    // Level pins changed after power-up
    task automatic set_pins(input logic mode, input logic clr, input logic oe);
        @(negedge i_clk);
        o_mode_select_pin = mode;
        o_clear_pin = clr;
        o_output_enable_pin = oe;
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import odpoc_pkg::*;

    logic               i_clk, i_reset_n, i_mode_select_pin, i_clear_pin, i_output_enable_pin;
    logic               i_clear_level_select_pin, i_ctrl_write, i_ctrl_output_enable_bit;
    logic               i_ctrl_clear_level_select, o_voltage_output_pin_en;
    logic [RANGE_W-1:0] i_range_select_pins, i_ctrl_range_select, o_range;
    logic               o_current_output_pin_en, o_force_zero_volt, o_clear_active;
    logic               o_clear_level, o_output_enable_bit, o_hw_mode, o_ready;
    logic [7:0]         st;
    int                 err_total, compares, cycles;

    // Status bits packed for compact comparisons
    assign st = {o_voltage_output_pin_en, o_current_output_pin_en, o_force_zero_volt,
                 o_clear_active, o_clear_level, o_output_enable_bit, o_hw_mode, o_ready};

    odpoc_top dut (.i_clk, .i_reset_n, .i_mode_select_pin, .i_clear_pin, .i_output_enable_pin,
        .i_clear_level_select_pin, .i_range_select_pins, .i_ctrl_write, .i_ctrl_range_select,
        .i_ctrl_output_enable_bit, .i_ctrl_clear_level_select, .o_voltage_output_pin_en,
        .o_current_output_pin_en, .o_force_zero_volt, .o_clear_active, .o_clear_level,
        .o_range, .o_output_enable_bit, .o_hw_mode, .o_ready);

    odpoc_host_model host (.i_clk, .o_reset_n(i_reset_n), .o_mode_select_pin(i_mode_select_pin),
        .o_clear_pin(i_clear_pin), .o_output_enable_pin(i_output_enable_pin),
        .o_clear_level_select_pin(i_clear_level_select_pin),
        .o_range_select_pins(i_range_select_pins), .o_ctrl_write(i_ctrl_write),
        .o_ctrl_range_select(i_ctrl_range_select),
        .o_ctrl_output_enable_bit(i_ctrl_output_enable_bit),
        .o_ctrl_clear_level_select(i_ctrl_clear_level_select));

    // 20 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready(input int extra);
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 30)
        begin
            @(negedge i_clk);
            n++;
        end
        repeat (extra) @(negedge i_clk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            err_total++;
            end_sim();
        end
    end

    initial
    begin
        err_total = 0;
        compares = 0;
        cycles = 0;
        // Software mode, clear low: idle, then every range code
        host.power_up(1'b0, 1'b0, 4'h0);
        wait_ready(2);
        chk(st, 8'h01);
        chk({4'h0, o_range}, 8'h00);
        for (int r = 0; r < 16; r++)
        begin
            host.ctrl_write(4'(r), 1'b1, r[0]);
            repeat (2) @(negedge i_clk);
            chk(st, {~r[3], r[3], 2'b00, r[0], 3'b101});
            chk({4'h0, o_range}, 8'(r));
        end
        host.ctrl_write(4'h3, 1'b0, 1'b0);
        repeat (2) @(negedge i_clk);
        chk(st, 8'h01);
        // Software mode, clear high: 0 V driven, clear state, exit
        host.power_up(1'b0, 1'b1, 4'h0);
        wait_ready(2);
        chk(st, 8'hA1);
        host.ctrl_write(4'h9, 1'b1, 1'b1);
        repeat (2) @(negedge i_clk);
        chk(st, 8'h5D);
        host.set_pins(1'b0, 1'b0, 1'b0);
        repeat (8) @(negedge i_clk);
        chk(st, 8'h4D);
        // Hardware mode: pins rule, clear follows its pin, writes refused, mode held
        host.power_up(1'b1, 1'b0, 4'h2);
        wait_ready(2);
        chk(st, 8'h0B);
        chk({4'h0, o_range}, 8'h02);
        host.set_pins(1'b1, 1'b0, 1'b1);
        repeat (8) @(negedge i_clk);
        chk(st, 8'h8B);
        host.set_pins(1'b1, 1'b1, 1'b1);
        repeat (8) @(negedge i_clk);
        chk(st, 8'h9B);
        host.set_pins(1'b1, 1'b0, 1'b1);
        repeat (8) @(negedge i_clk);
        chk(st, 8'h8B);
        host.ctrl_write(4'hF, 1'b1, 1'b0);
        repeat (2) @(negedge i_clk);
        chk(st, 8'h8B);
        chk({4'h0, o_range}, 8'h02);
        host.set_pins(1'b0, 1'b0, 1'b1);
        repeat (8) @(negedge i_clk);
        chk(st, 8'h8B);
        end_sim();
    end
endmodule
